//--- logic/bace_pkg.sv
/*
 * bace_pkg: shared constants and carriers of the block arithmetic command engine.
 * Assumes a 24-bit byte-addressed shared memory reached as 16-bit half-words.
 */
package bace_pkg;

	// shared memory geometry
	localparam int AW = 24;
	localparam int DW = 16;

	// command stack layout: six 32-bit fields, byte offset = index * 4
	localparam logic [2:0] STK_OP   = 3'h0;
	localparam logic [2:0] STK_CNT  = 3'h1;
	localparam logic [2:0] STK_TYPE = 3'h2;
	localparam logic [2:0] STK_SRC  = 3'h3;
	localparam logic [2:0] STK_DST  = 3'h4;
	localparam logic [2:0] STK_LINK = 3'h5;

	// operation word fields
	localparam int CMD_OPC_LSB  = 24;
	localparam int CMD_FMT_LSB  = 22;
	localparam int CNT_LOOP_LSB = 16;
	localparam logic [7:0] OP_COUNT = 8'h55;
	localparam logic [3:0] MICRO_STEP = 4'h0;

	// data formats
	localparam logic [1:0] FMT_INT16 = 2'h0;
	localparam logic [1:0] FMT_SGL   = 2'h1;
	localparam logic [1:0] FMT_DBL   = 2'h2;

	// integer operation kinds, low two bits of the opcode
	localparam logic [1:0] OPK_ADD = 2'h0;
	localparam logic [1:0] OPK_SUB = 2'h1;
	localparam logic [1:0] OPK_MUL = 2'h2;
	localparam logic [1:0] OPK_DIV = 2'h3;

	typedef enum logic [2:0] {
		ST_WAIT   = 3'b000,
		ST_FETCH  = 3'b001,
		ST_DECODE = 3'b010,
		ST_RD     = 3'b011,
		ST_WR     = 3'b100,
		ST_NEXT   = 3'b101,
		ST_ERR    = 3'b110
	} bace_st_t;

	typedef enum logic [1:0] {
		MP_IDLE = 2'b00,
		MP_REQ  = 2'b01,
		MP_STB  = 2'b10,
		MP_REL  = 2'b11
	} bace_mp_t;

	// sampled pins, all asynchronous to the engine clock
	typedef struct packed {
		logic          match_n;
		logic          grant_n;
		logic          strobe_n;
		logic          clr;
		logic [23:0]   hdata;
		logic [15:0]   rdata;
	} bace_pins_t;

	typedef struct packed {
		bace_st_t      st;
		bace_mp_t      mph;
		logic [2:0]    fld;
		bace_pins_t    s1;
		bace_pins_t    s2;
		logic [23:0]   ptr;
		logic [31:0]   cmd;
		logic [15:0]   cnt;
		logic [7:0]    loops;
		logic          cplx;
		logic [23:0]   src;
		logic [23:0]   dst;
		logic [23:0]   link;
		logic [17:0]   units;
		logic [17:0]   idx;
		logic [23:0]   maddr;
		logic          mtwo;
		logic          mwr;
		logic          mhalf;
		logic          mdone;
		logic [31:0]   mdata;
		logic [15:0]   wdata;
		logic          req_n;
		logic          bit1_n;
		logic          dtack_n;
		logic          irq_n;
		logic          flag;
		logic          go;
		logic          err;
		logic          busy;
		logic [11:0]   micro;
	} bace_state_t;

	localparam bace_pins_t PINS_IDLE = '{match_n: 1'b1, grant_n: 1'b1, strobe_n: 1'b1,
		default: '0};
	localparam bace_state_t STATE_RST = '{s1: PINS_IDLE, s2: PINS_IDLE, req_n: 1'b1,
		bit1_n: 1'b1, dtack_n: 1'b1, irq_n: 1'b1, st: ST_WAIT, mph: MP_IDLE, default: '0};

endpackage

//--- logic/bace_engine.sv
/*
 * bace_engine: command stack interpreter with host pointer handshake and
 * request/grant access to shared memory.
 * Assumes host and memory pins are asynchronous; one clock, i_ce freezes all.
 */
// Notes on behaviour
// - data blocks are 16-bit integer, 32-bit single or 64-bit double.
// - 85 operations exist; higher opcodes are refused as errors.
// - commands run singly or chained in series, with repeat loops.
// - own address match raises load flag and captures host data as pointer.
// - acknowledge returns after capture; host holds lines until acknowledged.
// - the handshake also pulses the sequencer go condition.
// - pointer moves to working storage, then operation word is fetched.
// - source address kept; opcode mapped to microprogram start address.
// - interrupt raised per finished command and on every error.
// - results are written at the stack destination address.
// - next stack follows until done; reset or error stops early.
// - when done, wait loop until a new load flag.
// - 32-bit access is two half-words, second with address bit 1 inverted.
// - first half-word is high mantissa, second low mantissa plus exponent.
// - request once, then wait grant, data strobe, grant drop per half-word.
// - interrupt stays asserted until the clear input removes it.

`timescale 1ns/1ps

module bace_engine (
	input  wire logic         i_sys_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_ce,
	input  wire logic         i_own_address_match_n,
	input  wire logic [23:0]  i_host_data,
	output logic              o_host_dtack_n,
	output logic              o_pointer_load_flag,
	output logic              o_sequencer_go_condition,
	output logic [11:0]       o_micro_start,
	output logic              o_shared_mem_request_n,
	input  wire logic         i_shared_mem_grant_n,
	input  wire logic         i_shared_mem_data_strobe_n,
	input  wire logic [15:0]  i_mem_rdata,
	output logic [23:2]       o_mem_addr,
	output logic              o_shared_mem_addr_bit1_n,
	output logic              o_mem_we,
	output logic [15:0]       o_mem_wdata,
	output logic              o_engine_irq_n,
	input  wire logic         i_engine_irq_clear,
	output logic              o_error,
	output logic              o_busy
);

	bace_pkg::bace_state_t r;
	bace_pkg::bace_state_t n;
	logic [1:0]  fmt;

	assign fmt = r.cmd[bace_pkg::CMD_FMT_LSB +: 2];

	// byte address of element unit idx; integers are 2 bytes, floats go by 4
	function automatic logic [23:0] unit_addr(input logic [23:0] base,
		input logic [17:0] idx, input logic [1:0] f);
		if (f == bace_pkg::FMT_INT16) begin
			unit_addr = base + {5'h00, idx, 1'b0};
		end else begin
			unit_addr = base + {4'h0, idx, 2'b00};
		end
	endfunction

	// integer element against immediate; divide by zero is caught in decode
	function automatic logic [15:0] int_op(input logic [1:0] k, input logic [15:0] a,
		input logic [15:0] b);
		case (k)
			bace_pkg::OPK_ADD: int_op = a + b;
			bace_pkg::OPK_SUB: int_op = a - b;
			bace_pkg::OPK_MUL: int_op = 16'(signed'(a) * signed'(b));
			bace_pkg::OPK_DIV: int_op = 16'(signed'(a) / signed'(b));
			default:           int_op = a;
		endcase
	endfunction

	// next state: sync stages, memory sequencer, then command flow
	always_comb begin
		logic        go_mem;
		logic [23:0] go_addr;
		logic        go_two;
		logic        go_wr;
		logic [31:0] go_data;
		logic        set_irq;
		go_mem  = 1'b0;
		go_addr = r.ptr;
		go_two  = 1'b1;
		go_wr   = 1'b0;
		go_data = r.mdata;
		set_irq = 1'b0;
		n = r;
		n.s1 = '{match_n: i_own_address_match_n, grant_n: i_shared_mem_grant_n,
			strobe_n: i_shared_mem_data_strobe_n, clr: i_engine_irq_clear,
			hdata: i_host_data, rdata: i_mem_rdata};
		n.s2 = r.s1;
		n.flag = 1'b0;
		n.go = 1'b0;
		n.mdone = 1'b0;
		// host drops its lines once acknowledged, then acknowledge is withdrawn
		if (r.s2.match_n && !r.dtack_n) begin
			n.dtack_n = 1'b1;
		end

		// one half-word per grant; request held across both halves
		case (r.mph)
			bace_pkg::MP_REQ: begin
				n.req_n = 1'b0;
				if (!r.s2.grant_n) begin
					n.mph = bace_pkg::MP_STB;
				end
			end
			bace_pkg::MP_STB: begin
				if (!r.s2.strobe_n) begin
					if (!r.mwr && r.mtwo && !r.mhalf) begin
						n.mdata[31:16] = r.s2.rdata;
					end else if (!r.mwr) begin
						n.mdata[15:0] = r.s2.rdata;
					end
					n.mph = bace_pkg::MP_REL;
				end
			end
			bace_pkg::MP_REL: begin
				if (r.s2.grant_n) begin
					if (r.mtwo && !r.mhalf) begin
						n.mhalf = 1'b1;
						n.bit1_n = r.maddr[1];
						n.wdata = r.mdata[15:0];
						n.mph = bace_pkg::MP_REQ;
					end else begin
						n.req_n = 1'b1;
						n.mph = bace_pkg::MP_IDLE;
						n.mdone = 1'b1;
					end
				end
			end
			default: ;
		endcase

		case (r.st)
			bace_pkg::ST_WAIT: begin
				// wait loop; new pointer only taken here, never mid-run
				if (!r.s2.match_n && r.dtack_n) begin
					n.ptr = r.s2.hdata;
					n.flag = 1'b1;
					n.dtack_n = 1'b0;
					n.go = 1'b1;
					n.err = 1'b0;
					n.fld = bace_pkg::STK_OP;
					go_mem = 1'b1;
					go_addr = r.s2.hdata;
					n.st = bace_pkg::ST_FETCH;
				end
			end
			bace_pkg::ST_FETCH: begin
				if (r.mdone) begin
					case (r.fld)
						bace_pkg::STK_OP:   n.cmd = r.mdata;
						bace_pkg::STK_CNT: begin
							n.cnt = r.mdata[15:0];
							n.loops = r.mdata[bace_pkg::CNT_LOOP_LSB +: 8];
						end
						bace_pkg::STK_TYPE: n.cplx = r.mdata[0];
						bace_pkg::STK_SRC:  n.src = r.mdata[23:0];
						bace_pkg::STK_DST:  n.dst = r.mdata[23:0];
						default:            n.link = r.mdata[23:0];
					endcase
					if (r.fld == bace_pkg::STK_LINK) begin
						n.st = bace_pkg::ST_DECODE;
					end else begin
						n.fld = r.fld + 3'h1;
						go_mem = 1'b1;
						go_addr = r.ptr + {19'h00000, r.fld + 3'h1, 2'b00};
					end
				end
			end
			bace_pkg::ST_DECODE: begin
				n.micro = {r.cmd[bace_pkg::CMD_OPC_LSB +: 8], bace_pkg::MICRO_STEP};
				n.idx = '0;
				n.units = {2'b00, r.cnt} << ({1'b0, r.cplx} + {1'b0, fmt == bace_pkg::FMT_DBL});
				if (r.cmd[bace_pkg::CMD_OPC_LSB +: 8] >= bace_pkg::OP_COUNT || fmt > bace_pkg::FMT_DBL
					|| (fmt == bace_pkg::FMT_INT16
					&& r.cmd[bace_pkg::CMD_OPC_LSB +: 2] == bace_pkg::OPK_DIV
					&& r.cmd[15:0] == 16'h0000)) begin
					n.st = bace_pkg::ST_ERR;
				end else if (r.cnt == 16'h0000) begin
					n.st = bace_pkg::ST_NEXT;
				end else begin
					go_mem = 1'b1;
					go_addr = r.src;
					go_two = (fmt != bace_pkg::FMT_INT16);
					n.st = bace_pkg::ST_RD;
				end
			end
			bace_pkg::ST_RD: begin
				// floats are moved whole; integers take the immediate operand
				if (r.mdone) begin
					if (fmt == bace_pkg::FMT_INT16) begin
						go_data = {16'h0000, int_op(r.cmd[bace_pkg::CMD_OPC_LSB +: 2],
							r.mdata[15:0],
							r.cmd[15:0])};
					end
					go_mem = 1'b1;
					go_wr = 1'b1;
					go_two = (fmt != bace_pkg::FMT_INT16);
					go_addr = unit_addr(r.dst, r.idx, fmt);
					n.st = bace_pkg::ST_WR;
				end
			end
			bace_pkg::ST_WR: begin
				if (r.mdone) begin
					n.idx = r.idx + 18'h00001;
					if (r.idx + 18'h00001 == r.units) begin
						n.st = bace_pkg::ST_NEXT;
					end else begin
						go_mem = 1'b1;
						go_two = (fmt != bace_pkg::FMT_INT16);
						go_addr = unit_addr(r.src, r.idx + 18'h00001, fmt);
						n.st = bace_pkg::ST_RD;
					end
				end
			end
			bace_pkg::ST_NEXT: begin
				set_irq = 1'b1;
				if (r.loops != 8'h00) begin
					n.loops = r.loops - 8'h01;
					n.st = bace_pkg::ST_DECODE;
				end else if (r.link == 24'h000000) begin
					n.st = bace_pkg::ST_WAIT;
				end else begin
					n.ptr = r.link;
					n.fld = bace_pkg::STK_OP;
					go_mem = 1'b1;
					go_addr = r.link;
					n.st = bace_pkg::ST_FETCH;
				end
			end
			bace_pkg::ST_ERR: begin
				set_irq = 1'b1;
				n.err = 1'b1;
				n.st = bace_pkg::ST_WAIT;
			end
			default: n.st = bace_pkg::ST_WAIT;
		endcase

		// launch a transfer; first half of a pair carries the high word
		if (go_mem) begin
			n.mph = bace_pkg::MP_REQ;
			n.maddr = go_addr;
			n.mtwo = go_two;
			n.mwr = go_wr;
			n.mhalf = 1'b0;
			n.mdata = go_data;
			n.bit1_n = ~go_addr[1];
			n.wdata = go_two ? go_data[31:16] : go_data[15:0];
		end

		// set beats clear so a completion is never lost
		if (set_irq) begin
			n.irq_n = 1'b0;
		end else if (r.s2.clr) begin
			n.irq_n = 1'b1;
		end
		n.busy = (n.st != bace_pkg::ST_WAIT);
	end

	// whole state in one register; i_ce low freezes it
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= bace_pkg::STATE_RST;
		end else if (i_ce) begin
			r <= n;
		end
	end

	assign o_host_dtack_n           = r.dtack_n;
	assign o_pointer_load_flag      = r.flag;
	assign o_sequencer_go_condition = r.go;
	assign o_micro_start            = r.micro;
	assign o_shared_mem_request_n   = r.req_n;
	assign o_mem_addr               = r.maddr[23:2];
	assign o_shared_mem_addr_bit1_n = r.bit1_n;
	assign o_mem_we                 = r.mwr;
	assign o_mem_wdata              = r.wdata;
	assign o_engine_irq_n           = r.irq_n;
	assign o_error                  = r.err;
	assign o_busy                   = r.busy;

	// checks on handshake, memory sequencing and interrupt
	property p_load;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		r.flag |-> !r.dtack_n && r.go && r.ptr == r.maddr;
	endproperty
	a_load: assert property (p_load) else $error("pointer capture not paired");

	property p_ack;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		$fell(r.dtack_n) |-> r.flag && r.st == bace_pkg::ST_FETCH;
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge without capture");

	property p_busy_ignore;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		r.st != bace_pkg::ST_WAIT && i_ce |=> !r.flag;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("flag taken while busy");

	property p_bit1;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		r.mph == bace_pkg::MP_STB && r.mhalf |-> r.bit1_n == r.maddr[1] && !r.req_n;
	endproperty
	a_bit1: assert property (p_bit1) else $error("second half address wrong");

	property p_high_first;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		i_ce && r.mph == bace_pkg::MP_STB && !r.s2.strobe_n && r.mtwo && !r.mhalf && !r.mwr
		|=> r.mdata[31:16] == $past(r.s2.rdata);
	endproperty
	a_high_first: assert property (p_high_first) else $error("first half not high");

	property p_irq_cmd;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		i_ce && r.st == bace_pkg::ST_NEXT |=> !r.irq_n;
	endproperty
	a_irq_cmd: assert property (p_irq_cmd) else $error("no interrupt after command");

	property p_irq_hold;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		!r.irq_n && !r.s2.clr |=> !r.irq_n;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");

	property p_err_stop;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		i_ce && r.st == bace_pkg::ST_ERR |=> r.st == bace_pkg::ST_WAIT && r.err && !r.irq_n;
	endproperty
	a_err_stop: assert property (p_err_stop) else $error("error did not stop run");

	property p_bad_op;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		i_ce && r.st == bace_pkg::ST_DECODE && r.cmd[31:24] >= bace_pkg::OP_COUNT
		|=> r.st == bace_pkg::ST_ERR;
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("bad opcode accepted");

	property p_dest;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		r.st == bace_pkg::ST_WR && r.mph == bace_pkg::MP_REQ
		|-> r.mwr && r.maddr == unit_addr(r.dst, r.idx, fmt);
	endproperty
	a_dest: assert property (p_dest) else $error("result address wrong");

	c_start: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) r.flag);
	c_done: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
		r.st == bace_pkg::ST_NEXT && r.link == 24'h000000 && r.loops == 8'h00);
	c_err: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) r.st == bace_pkg::ST_ERR);
	c_repeat: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
		r.st == bace_pkg::ST_NEXT && r.loops != 8'h00);

endmodule

//--- dv/bace_mem_model.sv
/*
 * bace_mem_model: shared memory with request/grant/strobe handshake.
 * Assumes engine outputs change on rising edges; this model acts on falling ones.
 */
`timescale 1ns/1ps
module bace_mem_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_shared_mem_request_n,
	input  wire logic [23:2] i_mem_addr,
	input  wire logic        i_shared_mem_addr_bit1_n,
	input  wire logic        i_mem_we,
	input  wire logic [15:0] i_mem_wdata,
	input  wire logic [3:0]  i_lat,
	output logic             o_shared_mem_grant_n,
	output logic             o_shared_mem_data_strobe_n,
	output logic [15:0]      o_mem_rdata
);
	logic [15:0] mem [logic [23:0]];
	logic [23:0] a;
	logic [23:2] a0;
	logic        pb1;
	logic        half;
	int          bad;
	int          n;

	// one half-word per grant, grant dropped after each half
	initial begin
		o_shared_mem_grant_n = 1'b1;
		o_shared_mem_data_strobe_n = 1'b1;
		o_mem_rdata = 16'h0;
		bad = 0;
		half = 1'b0;
		forever begin
			@(negedge i_sys_clk);
			if (i_shared_mem_request_n) begin
				half = 1'b0;
			end else begin
				a = {i_mem_addr, ~i_shared_mem_addr_bit1_n, 1'b0};
				// a second half in one request must keep the word, flip bit 1
				if (half && (i_mem_addr !== a0 || i_shared_mem_addr_bit1_n === pb1))
					bad++;
				a0 = i_mem_addr;
				pb1 = i_shared_mem_addr_bit1_n;
				half = 1'b1;
				repeat (i_lat) @(negedge i_sys_clk);
				o_shared_mem_grant_n = 1'b0;
				@(negedge i_sys_clk);
				if (i_mem_we)
					mem[a] = i_mem_wdata;
				else
					o_mem_rdata = mem.exists(a) ? mem[a] : 16'hdead;
				o_shared_mem_data_strobe_n = 1'b0;
				repeat (3) @(negedge i_sys_clk);
				// released bus shows the inverse, not a stale value
				o_mem_rdata = ~o_mem_rdata;
				o_shared_mem_data_strobe_n = 1'b1;
				o_shared_mem_grant_n = 1'b1;
				n = 0;
				while (!i_shared_mem_request_n && i_shared_mem_addr_bit1_n === pb1 && n < 20) begin
					@(negedge i_sys_clk);
					n++;
				end
			end
		end
	end
endmodule

//--- dv/tb.sv
/*
 * tb: self-checking bench of bace_engine against the shared memory model.
 * Assumes the stack layout and field positions of bace_pkg.
 */
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic [7:0]  opc;
		logic [1:0]  fmt;
		logic [15:0] imm;
		logic [31:0] din;
		logic [31:0] dexp;
	} bace_row_t;

	logic        i_sys_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic        i_own_address_match_n = 1'b1;
	logic [23:0] i_host_data = 24'h0;
	logic        i_engine_irq_clear = 1'b0;
	logic [3:0]  lat = 4'h1;
	logic        o_host_dtack_n, o_pointer_load_flag, o_sequencer_go_condition, o_mem_we;
	logic        o_shared_mem_request_n, o_shared_mem_addr_bit1_n, o_engine_irq_n;
	logic        o_error, o_busy, gnt_n, stb_n;
	logic [11:0] o_micro_start;
	logic [23:2] o_mem_addr;
	logic [15:0] o_mem_wdata, rdata;
	int          err_total = 0;
	int          compares = 0;
	int          cyc = 0;
	bace_row_t   rows [6] = '{
		'{{6'h04, bace_pkg::OPK_ADD}, bace_pkg::FMT_INT16, 16'h0005, 32'h0003, 32'h0008},
		'{{6'h04, bace_pkg::OPK_SUB}, bace_pkg::FMT_INT16, 16'h0004, 32'h0001, 32'hfffd},
		'{{6'h04, bace_pkg::OPK_MUL}, bace_pkg::FMT_INT16, 16'hfffd, 32'h0007, 32'hffeb},
		'{{6'h04, bace_pkg::OPK_DIV}, bace_pkg::FMT_INT16, 16'hfffb, 32'h0064, 32'hffec},
		'{8'h20, bace_pkg::FMT_SGL, 16'h0000, 32'h40490fdb, 32'h40490fdb},
		'{8'h54, bace_pkg::FMT_DBL, 16'h0000, 32'h3ff00001, 32'h3ff00001}
	};

	bace_engine u_bace_engine (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(1'b1),
		.i_own_address_match_n(i_own_address_match_n), .i_host_data(i_host_data),
		.o_host_dtack_n(o_host_dtack_n), .o_pointer_load_flag(o_pointer_load_flag),
		.o_sequencer_go_condition(o_sequencer_go_condition), .o_micro_start(o_micro_start),
		.o_shared_mem_request_n(o_shared_mem_request_n), .i_shared_mem_grant_n(gnt_n),
		.i_shared_mem_data_strobe_n(stb_n), .i_mem_rdata(rdata), .o_mem_addr(o_mem_addr),
		.o_shared_mem_addr_bit1_n(o_shared_mem_addr_bit1_n), .o_mem_we(o_mem_we),
		.o_mem_wdata(o_mem_wdata), .o_engine_irq_n(o_engine_irq_n),
		.i_engine_irq_clear(i_engine_irq_clear), .o_error(o_error), .o_busy(o_busy));

	bace_mem_model u_bace_mem_model (.i_sys_clk(i_sys_clk),
		.i_shared_mem_request_n(o_shared_mem_request_n), .i_mem_addr(o_mem_addr),
		.i_shared_mem_addr_bit1_n(o_shared_mem_addr_bit1_n), .i_mem_we(o_mem_we),
		.i_mem_wdata(o_mem_wdata), .i_lat(lat), .o_shared_mem_grant_n(gnt_n),
		.o_shared_mem_data_strobe_n(stb_n), .o_mem_rdata(rdata));

	// 20 MHz clock
	always #25 i_sys_clk = ~i_sys_clk;

	// hang guard, far above the few thousand cycles the run needs
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// 32-bit values: high half at the lower address
	task automatic p32(input logic [23:0] ad, input logic [31:0] d);
		u_bace_mem_model.mem[ad] = d[31:16];
		u_bace_mem_model.mem[ad + 24'h2] = d[15:0];
	endtask

	function automatic logic [31:0] g32(input logic [23:0] ad);
		return {u_bace_mem_model.mem[ad], u_bace_mem_model.mem[ad + 24'h2]};
	endfunction

	task automatic mkstk(input logic [23:0] b, input logic [7:0] opc, input logic [1:0] fmt,
			input logic [15:0] imm, input logic [15:0] cnt, input logic [23:0] src,
			input logic [23:0] dst, input logic [23:0] link);
		p32(b, {opc, fmt, 6'h00, imm});
		p32(b + 24'h4, {16'h0000, cnt});
		p32(b + 24'h8, 32'h0);
		p32(b + 24'hc, {8'h00, src});
		p32(b + 24'h10, {8'h00, dst});
		p32(b + 24'h14, {8'h00, link});
	endtask

	// host handshake; match and data held until the acknowledge
	task automatic start(input logic [23:0] p);
		int n;
		i_host_data = p;
		i_own_address_match_n = 1'b0;
		n = 0;
		while (o_host_dtack_n !== 1'b0 && n < 4000) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk("dtack", o_host_dtack_n, 1'b0);
		chk("flag", o_pointer_load_flag, 1'b1);
		chk("go", o_sequencer_go_condition, 1'b1);
		@(negedge i_sys_clk);
		chk("flag_end", o_pointer_load_flag, 1'b0);
		chk("go_end", o_sequencer_go_condition, 1'b0);
		i_own_address_match_n = 1'b1;
		i_host_data = ~p;
		n = 0;
		while (o_host_dtack_n !== 1'b1 && n < 10) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk("dtack_rel", o_host_dtack_n, 1'b1);
	endtask

	task automatic run_end();
		int n;
		n = 0;
		while (o_busy !== 1'b0 && n < 4000) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk("busy", o_busy, 1'b0);
		chk("req", o_shared_mem_request_n, 1'b1);
	endtask

	task automatic irq_clr();
		int n;
		i_engine_irq_clear = 1'b1;
		n = 0;
		while (o_engine_irq_n !== 1'b1 && n < 10) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk("irq_clr", o_engine_irq_n, 1'b1);
		i_engine_irq_clear = 1'b0;
		repeat (4) @(negedge i_sys_clk);
	endtask

	// reset values first, then rows, chaining, busy refusal, errors, repeats, reset mid-run
	initial begin
		repeat (8) @(negedge i_sys_clk);
		chk("rst_dtack", o_host_dtack_n, 1'b1);
		chk("rst_irq", o_engine_irq_n, 1'b1);
		chk("rst_req", o_shared_mem_request_n, 1'b1);
		i_nrst = 1'b1;
		repeat (2) @(negedge i_sys_clk);
		for (int i = 0; i < 6; i++) begin
			mkstk(24'h100, rows[i].opc, rows[i].fmt, rows[i].imm, 16'h1, 24'h1000, 24'h2000,
				24'h0);
			// blocks are in place before the command
			if (rows[i].fmt == bace_pkg::FMT_INT16) begin
				u_bace_mem_model.mem[24'h1000] = rows[i].din[15:0];
				u_bace_mem_model.mem[24'h2000] = ~rows[i].dexp[15:0];
			end else begin
				p32(24'h1000, rows[i].din);
				p32(24'h1004, ~rows[i].din);
				p32(24'h2000, 32'h0);
				p32(24'h2004, 32'h0);
			end
			start(24'h100);
			run_end();
			chk("irq", o_engine_irq_n, 1'b0);
			chk("err", o_error, 1'b0);
			chk("micro", o_micro_start, {rows[i].opc, bace_pkg::MICRO_STEP});
			if (rows[i].fmt == bace_pkg::FMT_INT16)
				chk("res16", u_bace_mem_model.mem[24'h2000], rows[i].dexp[15:0]);
			else
				chk("res32", g32(24'h2000), rows[i].dexp);
			if (rows[i].fmt == bace_pkg::FMT_DBL)
				chk("res64", g32(24'h2004), ~rows[i].din);
			irq_clr();
		end
		// two chained stacks with a slow memory, host knocking while busy
		lat = 4'h6;
		mkstk(24'h200, 8'h10, bace_pkg::FMT_INT16, 16'h0001, 16'h2, 24'h3000, 24'h3100, 24'h300);
		mkstk(24'h300, 8'h20, bace_pkg::FMT_SGL, 16'h0, 16'h1, 24'h3200, 24'h3300, 24'h0);
		p32(24'h3000, 32'h7fff8000);
		p32(24'h3200, 32'hc0a00001);
		start(24'h200);
		i_host_data = 24'h100;
		i_own_address_match_n = 1'b0;
		while (o_busy === 1'b1) begin
			chk("no_dtack", o_host_dtack_n, 1'b1);
			@(negedge i_sys_clk);
		end
		chk("chain_a", g32(24'h3100), 32'h80008001);
		chk("chain_b", g32(24'h3300), 32'hc0a00001);
		chk("chain_irq", o_engine_irq_n, 1'b0);
		start(24'h100);
		run_end();
		irq_clr();
		// refused opcode stops the chain before the linked stack
		lat = 4'h2;
		mkstk(24'h400, bace_pkg::OP_COUNT, bace_pkg::FMT_INT16, 16'h1, 16'h1, 24'h1000, 24'h3500,
			24'h300);
		u_bace_mem_model.mem[24'h3300] = 16'h5a5a;
		start(24'h400);
		run_end();
		chk("op_err", o_error, 1'b1);
		chk("err_irq", o_engine_irq_n, 1'b0);
		chk("no_link", u_bace_mem_model.mem[24'h3300], 16'h5a5a);
		repeat (20) @(negedge i_sys_clk);
		chk("irq_hold", o_engine_irq_n, 1'b0);
		irq_clr();
		// unused format code is an error too
		mkstk(24'h400, 8'h10, 2'h3, 16'h1, 16'h1, 24'h1000, 24'h3500, 24'h0);
		start(24'h400);
		run_end();
		chk("fmt_err", o_error, 1'b1);
		irq_clr();
		// integer divide by a zero immediate is refused, nothing written
		mkstk(24'h400, {6'h04, bace_pkg::OPK_DIV}, bace_pkg::FMT_INT16, 16'h0, 16'h1, 24'h1000,
			24'h3500, 24'h0);
		u_bace_mem_model.mem[24'h3500] = 16'h1234;
		start(24'h400);
		run_end();
		chk("div0_err", o_error, 1'b1);
		chk("div0_keep", u_bace_mem_model.mem[24'h3500], 16'h1234);
		irq_clr();
		// complex block, two extra repeats, added in place: three passes
		mkstk(24'h500, {6'h04, bace_pkg::OPK_ADD}, bace_pkg::FMT_INT16, 16'h0001, 16'h1,
			24'h3600, 24'h3600, 24'h0);
		p32(24'h504, 32'h00020001);
		p32(24'h508, 32'h00000001);
		p32(24'h3600, 32'h00100020);
		start(24'h500);
		run_end();
		chk("loop_res", g32(24'h3600), 32'h00130023);
		chk("loop_err", o_error, 1'b0);
		chk("loop_irq", o_engine_irq_n, 1'b0);
		irq_clr();
		// reset in mid-run ends processing
		lat = 4'h8;
		start(24'h200);
		repeat (30) @(negedge i_sys_clk);
		chk("mid_busy", o_busy, 1'b1);
		i_nrst = 1'b0;
		@(negedge i_sys_clk);
		chk("rst_busy", o_busy, 1'b0);
		chk("rst_req2", o_shared_mem_request_n, 1'b1);
		chk("rst_err", o_error, 1'b0);
		i_nrst = 1'b1;
		repeat (40) @(negedge i_sys_clk);
		chk("idle_busy", o_busy, 1'b0);
		chk("halves", u_bace_mem_model.bad, 32'h0);
		end_of_test();
	end
endmodule
